// file: core/bxc_params.svh
// Purpose : Offsets, codes, slots and reset values of the extended config bank
// Assumes : Byte addresses, one aligned 32-bit word per register
// Notes   : Included by the package and by every design file
`ifndef BXC_PARAMS_SVH
`define BXC_PARAMS_SVH
// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define BXC_AW            12
`define BXC_DW            32
`define BXC_BEW           4
`define BXC_LOG_AW        3
`define BXC_LOG_DEPTH     8
`define BXC_SLOTS         12
`define BXC_STS_N         3
// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define BXC_OFS_VENDOR    12'h000
`define BXC_OFS_HDR_TYPE  12'h00c
`define BXC_OFS_AER_CAP   12'h100
`define BXC_OFS_UNC_STS   12'h104
`define BXC_OFS_UNC_MSK   12'h108
`define BXC_OFS_UNC_SEV   12'h10c
`define BXC_OFS_COR_STS   12'h110
`define BXC_OFS_COR_MSK   12'h114
`define BXC_OFS_AER_CTL   12'h118
`define BXC_OFS_LOG_LO    12'h11c
`define BXC_OFS_LOG_HI    12'h128
`define BXC_OFS_SEC_STS   12'h12c
`define BXC_OFS_SEC_MSK   12'h130
`define BXC_OFS_SEC_SEV   12'h134
`define BXC_OFS_SEC_CTL   12'h138
`define BXC_OFS_SLOG_LO   12'h13c
`define BXC_OFS_SLOG_HI   12'h148
`define BXC_OFS_VC_CAP    12'h150
`define BXC_OFS_PVC_CAP1  12'h154
`define BXC_OFS_PVC_CAP2  12'h158
`define BXC_OFS_PVC_STC   12'h15c
`define BXC_OFS_CH0_CAP   12'h160
`define BXC_OFS_CH0_CTL   12'h164
`define BXC_OFS_CH0_STS   12'h168
`define BXC_OFS_GPIO      12'h300
`define BXC_OFS_GIO       12'h304
`define BXC_OFS_REPLAY    12'h310
// ----------------------------------------------------------------------
// Codes and read-only values
// ----------------------------------------------------------------------
`define BXC_AER_CAP_ID    16'h0001
`define BXC_VC_CAP_ID     16'h0002
`define BXC_CAP_VER       4'h1
`define BXC_AER_NEXT      12'h150
`define BXC_VC_NEXT       12'h000
`define BXC_HDR_TYPE1     8'h01
`define BXC_RO_ZERO       32'h0000_0000
`define BXC_RW_RST        32'h0000_0000
`define BXC_STS_RST       32'h0000_0000
// ----------------------------------------------------------------------
// Slot map of the writable words
// ----------------------------------------------------------------------
`define BXC_SLOT_UNC_MSK  4'h0
`define BXC_SLOT_UNC_SEV  4'h1
`define BXC_SLOT_COR_MSK  4'h2
`define BXC_SLOT_AER_CTL  4'h3
`define BXC_SLOT_SEC_MSK  4'h4
`define BXC_SLOT_SEC_SEV  4'h5
`define BXC_SLOT_SEC_CTL  4'h6
`define BXC_SLOT_PVC_STC  4'h7
`define BXC_SLOT_CH0_CTL  4'h8
`define BXC_SLOT_GPIO     4'h9
`define BXC_SLOT_GIO      4'ha
`define BXC_SLOT_REPLAY   4'hb
`define BXC_STICKY_SLOTS  12'h07f
`define BXC_STS_UNC       2'h0
`define BXC_STS_COR       2'h1
`define BXC_STS_SEC       2'h2
`define BXC_STICKY_STS    3'h3
`endif

// file: core/bxc_pkg.sv
// Purpose : Shared types of the extended config bank
// Assumes : bxc_params.svh holds every number
// Notes   : Types only
`include "bxc_params.svh"
package bxc_pkg;
  typedef logic [`BXC_AW-1:0]     bxc_addr_t;
  typedef logic [`BXC_DW-1:0]     bxc_word_t;
  typedef logic [`BXC_BEW-1:0]    bxc_be_t;
  typedef logic [`BXC_LOG_AW-1:0] bxc_log_addr_t;
  // Which port owns an access in flight
  typedef enum logic [1:0] {BXC_SRC_CFG, BXC_SRC_SMB, BXC_SRC_EE} bxc_src_e;
endpackage : bxc_pkg

// file: core/bxc_log_if.sv
// Purpose : Carrier between the bank and its header log store
// Assumes : One clock, write and read in the same cycle allowed
// Notes   : Read data is registered inside the store
`timescale 1ns/1ps
`include "bxc_params.svh"
interface bxc_log_if;
  logic                  we;
  bxc_pkg::bxc_log_addr_t waddr;
  bxc_pkg::bxc_word_t    wdata;
  bxc_pkg::bxc_log_addr_t raddr;
  bxc_pkg::bxc_word_t    rdata;
  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : bxc_log_if

// file: core/bxc_log_mem.sv
// Purpose : Eight-word store of the captured error headers
// Assumes : Written only by the error capture path
// Notes   : No reset on the array, so contents survive every reset
`timescale 1ns/1ps
`include "bxc_params.svh"
module bxc_log_mem (
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   rst_n,
  // Owner side
  bxc_log_if.store   lmem
);
  import bxc_pkg::*;

  bxc_word_t store_r [`BXC_LOG_DEPTH];
  bxc_word_t rdata_r;

  // Capture port; bus writes never reach here
  always_ff @(posedge ref_clk) begin
    if (lmem.we) begin
      store_r[lmem.waddr] <= lmem.wdata;
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `BXC_RO_ZERO;
    end else begin
      rdata_r <= store_r[lmem.raddr];
    end
  end

  assign lmem.rdata = rdata_r;

endmodule : bxc_log_mem

// file: core/bxc_ext_config.sv
// Purpose : Extended configuration register bank of the bridge
// Assumes : Config, SMBus and EEPROM ports all run on ref_clk
// Notes   : Every read answers two edges after it is taken
`timescale 1ns/1ps
`include "bxc_params.svh"

// Summary of operation
// - Decode extended region 100h to FFFh beside the conventional header.
// - Error reporting capability at 100h with identifier 0001h.
// - Virtual channel capability at 150h with identifier 0002h.
// - Word 300h reachable by config and SMBus, never loaded from EEPROM.
// - Word 304h reachable by config and SMBus, never loaded from EEPROM.
// - Writing one clears a write-one-clear bit; writing zero leaves it.
// - Sticky writable and sticky clearable fields survive the ordinary reset.
// - Sticky read-only fields ignore writes and survive the ordinary reset.
// - Offset 00h bits 15:0 always read the fixed vendor code.
// - Present a type 1 bridge header layout in transparent mode.
module bxc_ext_config #(
  parameter logic [15:0] VENDOR_CODE = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'ha5a5  // Arbitrary value
) (
  // Clock and resets
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic               hot_rst_n,
  // Configuration access
  input  wire logic               cfg_req,
  input  wire logic               cfg_wr,
  input  wire bxc_pkg::bxc_addr_t cfg_addr,
  input  wire bxc_pkg::bxc_word_t cfg_wdata,
  input  wire bxc_pkg::bxc_be_t   cfg_be,
  output wire logic               cfg_ack,
  output wire bxc_pkg::bxc_word_t cfg_rdata,
  // SMBus access
  input  wire logic               smb_req,
  input  wire logic               smb_wr,
  input  wire bxc_pkg::bxc_addr_t smb_addr,
  input  wire bxc_pkg::bxc_word_t smb_wdata,
  input  wire bxc_pkg::bxc_be_t   smb_be,
  output wire logic               smb_ack,
  output wire bxc_pkg::bxc_word_t smb_rdata,
  // EEPROM loader
  input  wire logic               ee_req,
  input  wire bxc_pkg::bxc_addr_t ee_addr,
  input  wire bxc_pkg::bxc_word_t ee_data,
  output wire logic               ee_ack,
  // Error events and header capture
  input  wire bxc_pkg::bxc_word_t unc_err_set,
  input  wire bxc_pkg::bxc_word_t cor_err_set,
  input  wire bxc_pkg::bxc_word_t sec_err_set,
  input  wire logic               log_wr,
  input  wire bxc_pkg::bxc_log_addr_t log_sel,
  input  wire bxc_pkg::bxc_word_t log_data,
  // Control words to the core
  output wire bxc_pkg::bxc_word_t gpio_ctl,
  output wire bxc_pkg::bxc_word_t gio_ctl,
  output wire bxc_pkg::bxc_word_t replay_timer
);
  import bxc_pkg::*;

  localparam logic [`BXC_SLOTS-1:0] STICKY_SLOTS = `BXC_STICKY_SLOTS;
  localparam logic [`BXC_STS_N-1:0] STICKY_STS   = `BXC_STICKY_STS;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Byte enables to a bit mask
  function automatic bxc_word_t be_mask(input bxc_be_t be);
    bxc_word_t m;
    m = `BXC_RO_ZERO;
    for (int b = 0; b < `BXC_BEW; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction : be_mask

  // Writable slot, {hit, index}
  function automatic logic [4:0] rw_slot(input bxc_addr_t a);
    unique case (a)
      `BXC_OFS_UNC_MSK: return {1'b1, `BXC_SLOT_UNC_MSK};
      `BXC_OFS_UNC_SEV: return {1'b1, `BXC_SLOT_UNC_SEV};
      `BXC_OFS_COR_MSK: return {1'b1, `BXC_SLOT_COR_MSK};
      `BXC_OFS_AER_CTL: return {1'b1, `BXC_SLOT_AER_CTL};
      `BXC_OFS_SEC_MSK: return {1'b1, `BXC_SLOT_SEC_MSK};
      `BXC_OFS_SEC_SEV: return {1'b1, `BXC_SLOT_SEC_SEV};
      `BXC_OFS_SEC_CTL: return {1'b1, `BXC_SLOT_SEC_CTL};
      `BXC_OFS_PVC_STC: return {1'b1, `BXC_SLOT_PVC_STC};
      `BXC_OFS_CH0_CTL: return {1'b1, `BXC_SLOT_CH0_CTL};
      `BXC_OFS_GPIO:    return {1'b1, `BXC_SLOT_GPIO};
      `BXC_OFS_GIO:     return {1'b1, `BXC_SLOT_GIO};
      `BXC_OFS_REPLAY:  return {1'b1, `BXC_SLOT_REPLAY};
      default:          return {1'b0, `BXC_SLOT_UNC_MSK};
    endcase
  endfunction : rw_slot

  // Clearable status word, {hit, index}
  function automatic logic [2:0] sts_slot(input bxc_addr_t a);
    unique case (a)
      `BXC_OFS_UNC_STS: return {1'b1, `BXC_STS_UNC};
      `BXC_OFS_COR_STS: return {1'b1, `BXC_STS_COR};
      `BXC_OFS_SEC_STS: return {1'b1, `BXC_STS_SEC};
      default:          return {1'b0, `BXC_STS_UNC};
    endcase
  endfunction : sts_slot

  // Header log word, {hit, store address}
  function automatic logic [3:0] log_slot(input bxc_addr_t a);
    bxc_addr_t d;
    d = '0;
    if (a >= `BXC_OFS_LOG_LO && a <= `BXC_OFS_LOG_HI) begin
      d = a - `BXC_OFS_LOG_LO;
      return {1'b1, 1'b0, d[3:2]};
    end else if (a >= `BXC_OFS_SLOG_LO && a <= `BXC_OFS_SLOG_HI) begin
      d = a - `BXC_OFS_SLOG_LO;
      return {1'b1, 1'b1, d[3:2]};
    end
    return {1'b0, 3'h0};
  endfunction : log_slot

  // Only these words accept a load from the EEPROM
  function automatic logic ee_loadable(input bxc_addr_t a);
    return (a == `BXC_OFS_UNC_MSK) || (a == `BXC_OFS_REPLAY);
  endfunction : ee_loadable

  // ----------------------------------------------------------------------
  // Ordinary reset synchroniser
  // ----------------------------------------------------------------------
  logic hot_meta_r;
  logic hot_sync_r;
  logic ord_rst;

  // Pin is asynchronous; second flop alone is read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hot_meta_r <= 1'b0;
      hot_sync_r <= 1'b0;
    end else begin
      hot_meta_r <= hot_rst_n;
      hot_sync_r <= hot_meta_r;
    end
  end

  assign ord_rst = ~hot_sync_r;

  // ----------------------------------------------------------------------
  // Port arbitration
  // ----------------------------------------------------------------------
  logic      smb_busy_r;
  logic      ee_busy_r;
  logic      smb_ack_r;
  logic      ee_ack_r;
  logic      smb_go;
  logic      ee_go;
  logic      acc_go;
  logic      acc_wr;
  bxc_src_e  acc_src;
  bxc_addr_t acc_addr;
  bxc_word_t acc_wdata;
  bxc_word_t acc_wmask;

  // Config never waits; SMBus then EEPROM take idle cycles
  assign smb_go = smb_req & ~cfg_req & ~smb_busy_r & ~smb_ack_r;
  assign ee_go  = ee_req & ~cfg_req & ~smb_req & ~ee_busy_r & ~ee_ack_r;

  // Select the single access of this cycle
  always_comb begin
    acc_go    = 1'b1;
    acc_wr    = cfg_wr;
    acc_src   = BXC_SRC_CFG;
    acc_addr  = cfg_addr;
    acc_wdata = cfg_wdata;
    acc_wmask = be_mask(cfg_be);
    if (!cfg_req) begin
      if (smb_go) begin
        acc_wr    = smb_wr;
        acc_src   = BXC_SRC_SMB;
        acc_addr  = smb_addr;
        acc_wdata = smb_wdata;
        acc_wmask = be_mask(smb_be);
      end else begin
        acc_go    = ee_go;
        acc_wr    = 1'b1;
        acc_src   = BXC_SRC_EE;
        acc_addr  = ee_addr;
        acc_wdata = ee_data;
        acc_wmask = ~`BXC_RO_ZERO;
      end
    end
  end

  // Busy flags stop a held request being taken twice
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smb_busy_r <= 1'b0;
      ee_busy_r  <= 1'b0;
    end else begin
      smb_busy_r <= smb_go | (smb_busy_r & ~smb_ack_r);
      ee_busy_r  <= ee_go | (ee_busy_r & ~ee_ack_r);
    end
  end

  // ----------------------------------------------------------------------
  // Writable words
  // ----------------------------------------------------------------------
  logic [4:0]            slot;
  logic [2:0]            sslot;
  logic                  wr_ok;
  logic [`BXC_SLOTS-1:0] rw_we;
  bxc_word_t             rw_r  [`BXC_SLOTS];
  bxc_word_t             sts_r [`BXC_STS_N];
  bxc_word_t             sts_set [`BXC_STS_N];

  assign slot  = rw_slot(acc_addr);
  assign sslot = sts_slot(acc_addr);
  // EEPROM loads are dropped outside their few words
  assign wr_ok = acc_go & acc_wr & ((acc_src != BXC_SRC_EE) | ee_loadable(acc_addr));

  // One write strobe per slot; reserved offsets hit none
  always_comb begin
    for (int i = 0; i < `BXC_SLOTS; i++) begin
      rw_we[i] = wr_ok & slot[4] & (slot[3:0] == 4'(i));
    end
  end

  // Byte-masked update; sticky slots ride through the ordinary reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `BXC_SLOTS; i++) begin
        rw_r[i] <= `BXC_RW_RST;
      end
    end else begin
      for (int i = 0; i < `BXC_SLOTS; i++) begin
        if (ord_rst && !STICKY_SLOTS[i]) begin
          rw_r[i] <= `BXC_RW_RST;
        end else if (rw_we[i]) begin
          rw_r[i] <= (rw_r[i] & ~acc_wmask) | (acc_wdata & acc_wmask);
        end
      end
    end
  end

  assign sts_set[`BXC_STS_UNC] = unc_err_set;
  assign sts_set[`BXC_STS_COR] = cor_err_set;
  assign sts_set[`BXC_STS_SEC] = sec_err_set;

  // Write-one-clear status; a new event beats a clear of the same bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `BXC_STS_N; i++) begin
        sts_r[i] <= `BXC_STS_RST;
      end
    end else begin
      for (int i = 0; i < `BXC_STS_N; i++) begin
        if (ord_rst && !STICKY_STS[i]) begin
          sts_r[i] <= sts_set[i];
        end else if (wr_ok && sslot[2] && sslot[1:0] == 2'(i)) begin
          sts_r[i] <= (sts_r[i] & ~(acc_wdata & acc_wmask)) | sts_set[i];
        end else begin
          sts_r[i] <= sts_r[i] | sts_set[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Header log store
  // ----------------------------------------------------------------------
  bxc_log_if  log_bus ();
  logic [3:0] lslot;

  assign lslot         = log_slot(acc_addr);
  assign log_bus.we    = log_wr;
  assign log_bus.waddr = log_sel;
  assign log_bus.wdata = log_data;
  assign log_bus.raddr = lslot[2:0];

  bxc_log_mem u_log_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .lmem    (log_bus.store)
  );

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  bxc_word_t rd_val;

  // Fixed words, live words; everything else reads zero
  always_comb begin
    rd_val = `BXC_RO_ZERO;
    if (slot[4]) begin
      rd_val = rw_r[slot[3:0]];
    end else if (sslot[2]) begin
      rd_val = sts_r[sslot[1:0]];
    end else begin
      case (acc_addr)
        `BXC_OFS_VENDOR:   rd_val = {DEVICE_CODE, VENDOR_CODE};
        `BXC_OFS_HDR_TYPE: rd_val = {8'h00, `BXC_HDR_TYPE1, 16'h0000};
        `BXC_OFS_AER_CAP:  rd_val = {`BXC_AER_NEXT, `BXC_CAP_VER, `BXC_AER_CAP_ID};
        `BXC_OFS_VC_CAP:   rd_val = {`BXC_VC_NEXT, `BXC_CAP_VER, `BXC_VC_CAP_ID};
        default:           rd_val = `BXC_RO_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Answer pipeline
  // ----------------------------------------------------------------------
  logic      s1_vld_r;
  logic      s1_log_r;
  bxc_src_e  s1_src_r;
  bxc_word_t s1_val_r;
  logic      cfg_ack_r;
  bxc_word_t cfg_rdata_r;
  bxc_word_t smb_rdata_r;
  bxc_word_t s2_word;

  // Stage one waits for the log store's registered read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_vld_r <= 1'b0;
      s1_log_r <= 1'b0;
      s1_src_r <= BXC_SRC_CFG;
      s1_val_r <= `BXC_RO_ZERO;
    end else begin
      s1_vld_r <= acc_go;
      s1_log_r <= lslot[3];
      s1_src_r <= acc_src;
      s1_val_r <= rd_val;
    end
  end

  assign s2_word = s1_log_r ? log_bus.rdata : s1_val_r;

  // Answer flops; data holds until the next answer on that port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_r   <= 1'b0;
      smb_ack_r   <= 1'b0;
      ee_ack_r    <= 1'b0;
      cfg_rdata_r <= `BXC_RO_ZERO;
      smb_rdata_r <= `BXC_RO_ZERO;
    end else begin
      cfg_ack_r <= s1_vld_r && s1_src_r == BXC_SRC_CFG;
      smb_ack_r <= s1_vld_r && s1_src_r == BXC_SRC_SMB;
      ee_ack_r  <= s1_vld_r && s1_src_r == BXC_SRC_EE;
      if (s1_vld_r && s1_src_r == BXC_SRC_CFG) begin
        cfg_rdata_r <= s2_word;
      end
      if (s1_vld_r && s1_src_r == BXC_SRC_SMB) begin
        smb_rdata_r <= s2_word;
      end
    end
  end

  assign cfg_ack      = cfg_ack_r;
  assign cfg_rdata    = cfg_rdata_r;
  assign smb_ack      = smb_ack_r;
  assign smb_rdata    = smb_rdata_r;
  assign ee_ack       = ee_ack_r;
  assign gpio_ctl     = rw_r[`BXC_SLOT_GPIO];
  assign gio_ctl      = rw_r[`BXC_SLOT_GIO];
  assign replay_timer = rw_r[`BXC_SLOT_REPLAY];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic cfg_rd;
  assign cfg_rd = cfg_req & ~cfg_wr;

  chk_cfg_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_req |-> ##2 cfg_ack_r) else $error("config request not answered in two edges");

  chk_aer_header: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == `BXC_OFS_AER_CAP |-> ##2 cfg_rdata_r[15:0] == `BXC_AER_CAP_ID)
    else $error("error capability identifier wrong");

  chk_vc_header: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == `BXC_OFS_VC_CAP |-> ##2 cfg_rdata_r[15:0] == `BXC_VC_CAP_ID)
    else $error("channel capability identifier wrong");

  chk_ee_gpio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ee_go && ee_addr == `BXC_OFS_GPIO |=> $stable(gpio_ctl))
    else $error("gpio word loaded from eeprom");

  chk_ee_gio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ee_go && ee_addr == `BXC_OFS_GIO |=> $stable(gio_ctl))
    else $error("general_input_output word loaded from eeprom");

  chk_w1c_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_req && cfg_wr && cfg_addr == `BXC_OFS_UNC_STS && unc_err_set == `BXC_RO_ZERO
    |=> (sts_r[`BXC_STS_UNC] & $past(cfg_wdata & be_mask(cfg_be))) == `BXC_RO_ZERO &&
        (sts_r[`BXC_STS_UNC] | $past(cfg_wdata & be_mask(cfg_be))) ==
        ($past(sts_r[`BXC_STS_UNC]) | $past(cfg_wdata & be_mask(cfg_be))))
    else $error("write-one-clear misbehaved");

  chk_sticky_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ord_rst && !wr_ok && unc_err_set == `BXC_RO_ZERO
    |=> sts_r[`BXC_STS_UNC] == $past(sts_r[`BXC_STS_UNC]) &&
        rw_r[`BXC_SLOT_UNC_MSK] == $past(rw_r[`BXC_SLOT_UNC_MSK]))
    else $error("sticky field lost on ordinary reset");

  chk_vendor_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == `BXC_OFS_VENDOR |-> ##2 cfg_rdata_r[15:0] == VENDOR_CODE)
    else $error("vendor code wrong");

  chk_type1_hdr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr == `BXC_OFS_HDR_TYPE |-> ##2 cfg_rdata_r[23:16] == `BXC_HDR_TYPE1)
    else $error("header type is not type 1");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_rd && cfg_addr > `BXC_OFS_REPLAY |-> ##2 cfg_rdata_r == `BXC_RO_ZERO)
    else $error("reserved offset read nonzero");

endmodule : bxc_ext_config

// file: dv/bxc_host_model.sv
// Purpose : Host model on the SMBus and EEPROM ports
// Assumes : One request outstanding, driven at falling edges
// Notes   : Released data lines show inverted data
`timescale 1ns/1ps
module bxc_host_model (
  // Clock
  input  wire logic               ref_clk,
  // Requests
  output logic                    smb_req,
  output logic                    smb_wr,
  output bxc_pkg::bxc_addr_t      smb_addr,
  output bxc_pkg::bxc_word_t      smb_wdata,
  output bxc_pkg::bxc_be_t        smb_be,
  output logic                    ee_req,
  output bxc_pkg::bxc_addr_t      ee_addr,
  output bxc_pkg::bxc_word_t      ee_data,
  // Answers
  input  wire logic               smb_ack,
  input  wire logic               ee_ack,
  input  wire bxc_pkg::bxc_word_t smb_rdata
);
  import bxc_pkg::*;
  // Answers seen in time; the bench compares the total
  int acks = 0;
  // Idle at time zero
  initial begin
    {smb_req, smb_wr, ee_req, smb_be, smb_addr, ee_addr} = '0;
    {smb_wdata, ee_data} = '0;
  end
  // Held until ack is sampled, dropped the cycle after so it is not retaken
  task automatic op(input logic ee, input logic wr, input bxc_addr_t a,
                    input bxc_word_t d, output bxc_word_t q);
    int n;
    @(negedge ref_clk);
    {smb_req, ee_req, smb_wr, smb_be} = {!ee, ee, wr, 4'hf};
    {smb_addr, ee_addr, smb_wdata, ee_data} = {a, a, d, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((ee ? ee_ack : smb_ack) !== 1'b1 && n < 20);
    if ((ee ? ee_ack : smb_ack) === 1'b1) begin
      acks++;
    end
    q = smb_rdata;
    @(negedge ref_clk);
    {smb_req, ee_req} = 2'b00;
    {smb_wdata, ee_data} = {~d, ~d};
  endtask : op
endmodule : bxc_host_model

// file: dv/tb_top.sv
// Purpose : Self-checking bench of the extended config bank
// Assumes : Host model owns the SMBus and EEPROM ports
// Notes   : Data from a fixed-seed xorshift
`timescale 1ns/1ps
`include "bxc_params.svh"
module tb_top;
  import bxc_pkg::*;
  localparam logic [15:0] VCODE = 16'h3c3c; // Arbitrary value
  logic ref_clk = 1'b0, rst_n = 1'b0, hot_rst_n = 1'b1;
  logic cfg_req = 1'b0, cfg_wr = 1'b0, log_wr = 1'b0;
  bxc_addr_t cfg_addr = '0, a;
  bxc_word_t cfg_wdata = '0, unc_err_set = '0, cor_err_set = '0, log_data = '0;
  bxc_be_t cfg_be = '0, smb_be;
  bxc_log_addr_t log_sel = '0;
  logic cfg_ack, smb_req, smb_wr, ee_req, smb_ack, ee_ack;
  bxc_addr_t smb_addr, ee_addr;
  bxc_word_t cfg_rdata, smb_wdata, smb_rdata, ee_data, gpio_ctl, gio_ctl, replay_timer;
  bxc_word_t q, d, e, m, x;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'd60897;
  bxc_ext_config #(.VENDOR_CODE(VCODE)) u_bxc_ext_config (
    .ref_clk, .rst_n, .hot_rst_n, .cfg_req, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_be,
    .cfg_ack, .cfg_rdata, .smb_req, .smb_wr, .smb_addr, .smb_wdata, .smb_be, .smb_ack,
    .smb_rdata, .ee_req, .ee_addr, .ee_data, .ee_ack, .unc_err_set, .cor_err_set,
    .sec_err_set(32'h0), .log_wr, .log_sel, .log_data, .gpio_ctl, .gio_ctl, .replay_timer);
  bxc_host_model u_bxc_host_model (
    .ref_clk, .smb_req, .smb_wr, .smb_addr, .smb_wdata, .smb_be, .ee_req, .ee_addr,
    .ee_data, .smb_ack, .ee_ack, .smb_rdata);
  // 100 ns clock
  initial forever #50 ref_clk = ~ref_clk;
  function automatic bxc_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Byte-enable merge of a write into an old word
  function automatic bxc_word_t merge(bxc_word_t o, bxc_word_t n, bxc_be_t be);
    for (int i = 0; i < 4; i++) if (be[i]) o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction : merge
  task automatic chk(input bxc_word_t got, input bxc_word_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle request; answer sampled at the edge where ack is high
  task automatic cfg(input logic wr, input bxc_addr_t ad, input bxc_word_t dv,
                     input bxc_be_t be);
    int n;
    @(negedge ref_clk);
    {cfg_req, cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'b1, wr, ad, dv, be};
    @(negedge ref_clk);
    {cfg_req, cfg_addr, cfg_wdata} = {1'b0, ~ad, ~dv};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cfg_ack !== 1'b1 && n < 6);
    q = cfg_rdata;
    chk({31'h0, cfg_ack}, 32'h1);
  endtask : cfg
  task automatic rd(input bxc_addr_t ad, input bxc_word_t exp);
    cfg(1'b0, ad, '0, '0);
    chk(q, exp);
  endtask : rd
  task automatic errp(input logic cor, input bxc_word_t v);
    @(negedge ref_clk);
    {unc_err_set, cor_err_set} = cor ? {32'h0, v} : {v, 32'h0};
    @(negedge ref_clk);
    {unc_err_set, cor_err_set} = '0;
  endtask : errp
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200_000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < 2; i++) begin
      cfg(1'b0, 12'h000, '0, '0);
      chk({16'h0, q[15:0]}, {16'h0, VCODE});
      cfg(1'b1, 12'h000, rnd(), 4'hf);
    end
    rd(12'h00c, {8'h00, `BXC_HDR_TYPE1, 16'h0});
    rd(12'h100, {`BXC_AER_NEXT, `BXC_CAP_VER, `BXC_AER_CAP_ID});
    rd(12'h150, {`BXC_VC_NEXT, `BXC_CAP_VER, `BXC_VC_CAP_ID});
    // Reserved words, the gap at 14Ch first
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      a = (i == 0) ? 12'h14c : (12'h400 | (d[11:0] & 12'h3fc));
      cfg(1'b1, a, d, 4'hf);
      rd(a, 32'h0);
    end
    x = 32'h0;
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      cfg(1'b1, 12'h310, d, d[3:0]);
      x = merge(x, d, d[3:0]);
      rd(12'h310, x);
      chk(replay_timer, x);
    end
    // Set, clear by one, then a zero write that must not clear
    x = 32'h0;
    for (int i = 0; i < 3; i++) begin
      e = rnd();
      m = rnd();
      errp(1'b0, e);
      x = (x | e) & ~m;
      cfg(1'b1, 12'h104, m, 4'hf);
      cfg(1'b1, 12'h104, 32'h0, 4'hf);
      rd(12'h104, x);
    end
    d = rnd();
    e = rnd();
    m = rnd();
    cfg(1'b1, 12'h108, d, 4'hf);
    errp(1'b1, e);
    @(negedge ref_clk);
    {log_wr, log_sel, log_data} = {1'b1, 3'h0, m};
    @(negedge ref_clk);
    log_wr = 1'b0;
    hot_rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    hot_rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(12'h108, d);
    rd(12'h110, e);
    rd(12'h104, x);
    rd(12'h310, 32'h0);
    cfg(1'b1, 12'h11c, ~m, 4'hf);
    rd(12'h11c, m);
    // SMBus writes stick, EEPROM loads of the same words are dropped
    d = rnd();
    e = rnd();
    u_bxc_host_model.op(1'b0, 1'b1, 12'h300, d, q);
    u_bxc_host_model.op(1'b0, 1'b1, 12'h304, e, q);
    u_bxc_host_model.op(1'b1, 1'b0, 12'h300, ~d, q);
    u_bxc_host_model.op(1'b1, 1'b0, 12'h304, ~e, q);
    u_bxc_host_model.op(1'b1, 1'b0, 12'h310, m, q);
    u_bxc_host_model.op(1'b0, 1'b0, 12'h300, '0, x);
    chk(x, d);
    rd(12'h304, e);
    chk(gpio_ctl, d);
    chk(gio_ctl, e);
    rd(12'h310, m);
    chk(32'(u_bxc_host_model.acks), 32'd6);
    close_out();
  end
endmodule : tb_top
